// [hdl/uart_dbuf_regs.svh]
// constants for the double-buffered uart core
// Contract
// - select 0, ninth one: flag during ninth bit
// - select 1: ninth zero no framing error
// - eleven low bit times set break flag
// - break window covers whole frame per mode
// - break flag held until cleared or reset
// - enabled break with enable bit: reset to programming
// - double buffer sends characters back to back
// - buffer off single; on accepts write while shifting
// - write to empty buffer loads, interrupts at once
// - last select zero: no further transmit interrupts
// - last select one: final interrupt at stop bit
// - queued character loads, interrupt at stop bit
// - double buffer stores ninth bit with byte
// - modes 2 and 3: nine bits, ninth stored
// - filter on: receive flag only when ninth one
// - filter ignored mode 0, kept clear mode 1
// - store only if flag clear and accepted
// - sixteen-fold sampling, majority of 7, 8, 9
// - framing error when stop bit not high
`ifndef UART_DBUF_REGS_SVH
`define UART_DBUF_REGS_SVH
`define UART_OVERSAMPLE 16
`define UART_BREAK_BITS 11
`define UART_BREAK_TICKS 8'(`UART_BREAK_BITS * `UART_OVERSAMPLE)
`define UART_TICK_S1 4'h7
`define UART_TICK_S2 4'h8
`define UART_TICK_S3 4'h9
`define UART_TICK_LAST 4'hf
`define UART_LAST_DATA_BIT 3'h7
`define UART_MODE0 2'h0
`define UART_MODE1 2'h1
`define UART_FIFO_DEPTH 4
`define UART_RST_BYTE 8'h00
`define UART_RST_LINE 1'h1
`endif

// [hdl/uart_dbuf_pkg.sv]
// types shared by the uart core
package uart_dbuf_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} rx_state_e;
  typedef struct packed {
    logic [1:0] mode;
    logic uart_enable;
    logic multiproc_filter_enable;
    logic framing_flag_select;
    logic tx_double_buffer_enable;
    logic tx_last_irq_select;
    logic tx_irq_position_select;
    logic break_reset_enable;
    logic tx_ninth_bit;
  } cfg_s;
  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic framing_error;
    logic brk;
  } flag_clr_s;
  typedef struct packed {
    logic rx_done_flag;
    logic tx_done_flag;
    logic framing_error_flag;
    logic break_flag;
    logic rx_ninth_bit;
  } flags_s;
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } tx_word_s;
endpackage

// [hdl/uart_dbuf_multiproc_break.sv]
// uart core: transmit buffer fifo, transmitter, receiver, break detect
`timescale 1ns/1ns
`include "uart_dbuf_regs.svh"

// small synchronous fifo, width and depth as parameters
module uart_word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // honest full and empty from the word count
  always_comb begin
    in_ready = count != (AW+1)'(DEPTH);
    out_valid = count != '0;
    out_data = mem[rd_ptr];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage has no reset; only words below count are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module uart_dbuf_multiproc_break
  import uart_dbuf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sample_tick,
  input wire cfg_s cfg,
  input wire flag_clr_s clr,
  input wire logic rxd,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic txd,
  output logic [7:0] rx_data,
  output flags_s flags,
  output logic isp_reset
);
  logic rst_meta, rst_n;
  logic nine_bit, active, db;
  logic fifo_valid, fifo_in_ready, fifo_in_valid, tx_pop;
  tx_word_s fifo_word;

  // majority of three samples, used by receiver and start check
  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  // reset released through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // mode 0 shifting is not part of this core, so transmitter and receiver idle there
  assign nine_bit = cfg.mode[1];
  assign active = cfg.uart_enable && (cfg.mode != `UART_MODE0);
  assign db = cfg.tx_double_buffer_enable;

  // single buffered: one character at a time, only when all idle
  tx_state_e tx_state, next_tx_state;
  assign fifo_in_valid = wr_valid && (db || (tx_state == TX_IDLE && !fifo_valid));
  assign wr_ready = fifo_in_ready && (db || (tx_state == TX_IDLE && !fifo_valid));

  uart_word_fifo #(.WIDTH(9), .DEPTH(`UART_FIFO_DEPTH)) tx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({cfg.tx_ninth_bit, wr_data}),
    .out_valid(fifo_valid),
    .out_ready(tx_pop),
    .out_data(fifo_word)
  );

  // transmitter state
  logic [3:0] tx_tick, next_tx_tick;
  logic [2:0] tx_bit, next_tx_bit;
  tx_word_s tx_shift, next_tx_shift;
  logic ti_given, next_ti_given, next_txd, ti_set, tx_last;

  always_comb begin
    next_tx_state = tx_state;
    next_tx_tick = sample_tick ? tx_tick + 4'h1 : tx_tick;
    next_tx_bit = tx_bit;
    next_tx_shift = tx_shift;
    next_ti_given = ti_given;
    next_txd = `UART_RST_LINE;
    ti_set = 1'b0;
    tx_pop = 1'b0;
    tx_last = sample_tick && (tx_tick == `UART_TICK_LAST);
    case (tx_state)
      TX_IDLE: begin
        next_tx_tick = 4'h0;
        if (active && fifo_valid) begin
          tx_pop = 1'b1;
          next_tx_shift = fifo_word;
          next_tx_state = TX_START;
          ti_set = db;
          next_ti_given = db;
        end
      end
      TX_START: begin
        next_txd = 1'b0;
        if (tx_last) begin
          next_tx_state = TX_DATA;
          next_tx_bit = 3'h0;
        end
      end
      TX_DATA: begin
        next_txd = tx_shift.data[tx_bit];
        if (tx_last) begin
          next_tx_bit = tx_bit + 3'h1;
          if (tx_bit == `UART_LAST_DATA_BIT) begin
            next_tx_state = nine_bit ? TX_NINTH : TX_STOP;
          end
        end
      end
      TX_NINTH: begin
        // single buffered reads the live bit, which software holds stable
        next_txd = db ? tx_shift.ninth : cfg.tx_ninth_bit;
        if (tx_last) begin
          next_tx_state = TX_STOP;
        end
      end
      TX_STOP: begin
        next_txd = 1'b1;
        if (tx_last) begin
          next_tx_state = TX_IDLE;
          next_ti_given = 1'b0;
          if (!db) begin
            ti_set = cfg.tx_irq_position_select;
          end else if (fifo_valid && active) begin
            // next character follows with one stop bit between
            tx_pop = 1'b1;
            next_tx_shift = fifo_word;
            next_tx_state = TX_START;
            next_tx_tick = 4'h0;
            ti_set = cfg.tx_irq_position_select || !ti_given;
          end else begin
            ti_set = cfg.tx_irq_position_select && cfg.tx_last_irq_select;
          end
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
    // start of stop bit: early interrupt position
    if (tx_last && next_tx_state == TX_STOP && !cfg.tx_irq_position_select) begin
      if (!db) begin
        ti_set = 1'b1;
      end else if (fifo_valid) begin
        ti_set = 1'b1;
        next_ti_given = 1'b1;
      end else begin
        ti_set = cfg.tx_last_irq_select;
        next_ti_given = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_tick <= 4'h0;
      tx_bit <= 3'h0;
      tx_shift <= '0;
      ti_given <= 1'b0;
      txd <= `UART_RST_LINE;
    end else begin
      tx_state <= next_tx_state;
      tx_tick <= next_tx_tick;
      tx_bit <= next_tx_bit;
      tx_shift <= next_tx_shift;
      ti_given <= next_ti_given;
      txd <= next_txd;
    end
  end

  // receiver state
  rx_state_e rx_state, next_rx_state;
  logic [3:0] rx_tick, next_rx_tick;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_shift, next_rx_shift;
  logic samp1, samp2, next_samp1, next_samp2;
  logic rx_ninth_q, next_rx_ninth_q, rx_early, next_rx_early, rxd_prev;
  logic vote, vote_now, rx_end, ri_set, fe_set, store_ninth;
  logic [7:0] store_data;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_tick = sample_tick ? rx_tick + 4'h1 : rx_tick;
    next_rx_bit = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_ninth_q = rx_ninth_q;
    next_rx_early = rx_early;
    next_samp1 = (sample_tick && rx_tick == `UART_TICK_S1) ? rxd : samp1;
    next_samp2 = (sample_tick && rx_tick == `UART_TICK_S2) ? rxd : samp2;
    vote = majority(samp1, samp2, rxd);
    vote_now = sample_tick && rx_tick == `UART_TICK_S3;
    rx_end = sample_tick && rx_tick == `UART_TICK_LAST;
    ri_set = 1'b0;
    fe_set = 1'b0;
    store_data = rx_shift;
    store_ninth = rx_ninth_q;
    case (rx_state)
      RX_IDLE: begin
        next_rx_tick = 4'h0;
        // falling edge restarts the sixteen-state bit counter
        if (active && rxd_prev && !rxd) begin
          next_rx_state = RX_START;
          next_rx_early = 1'b0;
        end
      end
      RX_START: begin
        if (vote_now && vote) begin
          next_rx_state = RX_IDLE;
        end else if (rx_end) begin
          next_rx_state = RX_DATA;
          next_rx_bit = 3'h0;
        end
      end
      RX_DATA: begin
        if (vote_now) begin
          next_rx_shift = {vote, rx_shift[7:1]};
        end
        if (rx_end) begin
          next_rx_bit = rx_bit + 3'h1;
          if (rx_bit == `UART_LAST_DATA_BIT) begin
            next_rx_state = nine_bit ? RX_NINTH : RX_STOP;
          end
        end
      end
      RX_NINTH: begin
        if (vote_now) begin
          next_rx_ninth_q = vote;
          // filtered address frame flagged one bit before the stop check
          if (cfg.multiproc_filter_enable && !cfg.framing_flag_select && vote
              && !flags.rx_done_flag) begin
            ri_set = 1'b1;
            store_ninth = vote;
            next_rx_early = 1'b1;
          end
        end
        if (rx_end) begin
          next_rx_state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (vote_now) begin
          // back to idle mid stop bit so the next start edge is not missed
          next_rx_state = RX_IDLE;
          store_ninth = nine_bit ? rx_ninth_q : vote;
          if (!rx_early && !flags.rx_done_flag
              && (!cfg.multiproc_filter_enable || store_ninth)) begin
            ri_set = 1'b1;
          end
          if (!vote && !(nine_bit && cfg.multiproc_filter_enable && cfg.framing_flag_select
              && !rx_ninth_q)) begin
            fe_set = 1'b1;
          end
        end
      end
      default: begin
        next_rx_state = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_tick <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= `UART_RST_BYTE;
      samp1 <= 1'b1;
      samp2 <= 1'b1;
      rx_ninth_q <= 1'b0;
      rx_early <= 1'b0;
      rxd_prev <= `UART_RST_LINE;
    end else begin
      rx_state <= next_rx_state;
      rx_tick <= next_rx_tick;
      rx_bit <= next_rx_bit;
      rx_shift <= next_rx_shift;
      samp1 <= next_samp1;
      samp2 <= next_samp2;
      rx_ninth_q <= next_rx_ninth_q;
      rx_early <= next_rx_early;
      rxd_prev <= rxd;
    end
  end

  // break detect: counts oversample ticks of continuous low line
  logic [7:0] low_cnt, next_low_cnt;
  logic brk_set, next_isp;

  always_comb begin
    brk_set = 1'b0;
    next_low_cnt = low_cnt;
    if (!cfg.uart_enable || rxd) begin
      next_low_cnt = 8'h00;
    end else if (sample_tick && low_cnt != `UART_BREAK_TICKS) begin
      // holds at the top so one long break sets the flag once
      next_low_cnt = low_cnt + 8'h01;
      brk_set = (low_cnt == `UART_BREAK_TICKS - 8'h01);
    end
    next_isp = brk_set && cfg.uart_enable && cfg.break_reset_enable;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 8'h00;
      isp_reset <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      isp_reset <= next_isp;
    end
  end

  // flags: hardware set beats a software clear in the same cycle
  flags_s next_flags;
  logic [7:0] next_rx_data;

  always_comb begin
    next_flags.rx_done_flag = ri_set || (flags.rx_done_flag && !clr.rx_done);
    next_flags.tx_done_flag = ti_set || (flags.tx_done_flag && !clr.tx_done);
    next_flags.framing_error_flag = fe_set || (flags.framing_error_flag && !clr.framing_error);
    next_flags.break_flag = brk_set || (flags.break_flag && !clr.brk);
    next_flags.rx_ninth_bit = ri_set ? store_ninth : flags.rx_ninth_bit;
    next_rx_data = ri_set ? store_data : rx_data;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
      rx_data <= `UART_RST_BYTE;
    end else begin
      flags <= next_flags;
      rx_data <= next_rx_data;
    end
  end
endmodule

// [test/uart_dbuf_multiproc_break_sva.sv]
// port assertions for the uart core
`timescale 1ns/1ns
module uart_port_chk
  import uart_dbuf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sample_tick,
  input wire cfg_s cfg,
  input wire flag_clr_s clr,
  input wire logic rxd,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic txd,
  input wire flags_s flags,
  input wire logic isp_reset
);
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  logic [7:0] next_low_cnt;
  logic [7:0] next_high_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // low ticks on rxd, idle cycles on txd; saturate so long idles never wrap
  always_comb begin
    next_low_cnt = rxd ? 8'h00 : low_cnt + 8'(sample_tick && low_cnt != 8'hff);
    next_high_cnt = !txd ? 8'h00 : high_cnt + 8'(high_cnt != 8'hff);
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 8'h00;
      high_cnt <= 8'h00;
    end else begin
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
    end
  end
  a_break_count: assert property ($rose(flags.break_flag) |-> low_cnt >= 8'hb0)
    else $error("break flag before eleven low bit times");
  a_break_held: assert property (flags.break_flag && !clr.brk |=> flags.break_flag)
    else $error("break flag dropped without clear");
  a_isp_cause: assert property (isp_reset |->
    $rose(flags.break_flag) && cfg.break_reset_enable && cfg.uart_enable)
    else $error("programming reset without enabled break");
  a_isp_pulse: assert property (isp_reset |=> !isp_reset)
    else $error("programming reset longer than one cycle");
  a_filter_ninth: assert property ($rose(flags.rx_done_flag) && cfg.multiproc_filter_enable
    && cfg.mode[1] |-> flags.rx_ninth_bit)
    else $error("filtered frame raised receive flag");
  a_fe_held: assert property (flags.framing_error_flag && !clr.framing_error
    |=> flags.framing_error_flag)
    else $error("framing flag dropped without clear");
  a_single_start: assert property (!cfg.tx_double_buffer_enable && cfg.uart_enable
    && cfg.mode != 2'h0 && wr_valid && wr_ready |-> ##[1:3] !txd)
    else $error("single buffer write did not start a frame");
  a_first_irq: assert property (cfg.tx_double_buffer_enable && cfg.uart_enable
    && cfg.mode != 2'h0 && wr_valid && wr_ready && high_cnt > 8'h30
    |-> ##[1:3] flags.tx_done_flag)
    else $error("no transmit flag on write to empty buffer");
endmodule
bind uart_dbuf_multiproc_break uart_port_chk uart_port_chk_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .sample_tick(sample_tick), .cfg(cfg), .clr(clr),
  .rxd(rxd), .wr_valid(wr_valid), .wr_ready(wr_ready), .txd(txd), .flags(flags),
  .isp_reset(isp_reset)
);

// [test/uart_remote_node.sv]
// behavioural remote uart node: frame sender on rxd, frame catcher on txd
`timescale 1ns/1ns
module uart_remote_node (
  input wire logic clk_sys,
  input wire logic sample_tick,
  input wire logic nine,
  input wire logic txd,
  output logic rxd,
  output logic in_stop,
  output logic got_ok,
  output logic [8:0] got,
  output logic [7:0] hi_run
);
  logic [7:0] hi_cnt = 8'h00;
  logic [8:0] w;
  initial begin
    rxd = 1'b1;
    in_stop = 1'b0;
    got_ok = 1'b0;
    got = 9'h000;
    hi_run = 8'h00;
  end
  // step n sample ticks on falling edges
  task automatic ticks(input int n);
    repeat (n) begin
      do @(negedge clk_sys); while (sample_tick !== 1'b1);
    end
  endtask
  // each bit held 16 ticks, lsb first, ninth last in nine-bit modes
  task automatic send(input logic [8:0] d, input logic stp);
    rxd = 1'b0;
    ticks(16);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      rxd = d[i];
      ticks(16);
    end
    in_stop = 1'b1;
    rxd = stp;
    ticks(16);
    in_stop = 1'b0;
    rxd = 1'b1;
  endtask
  // plain level for n cycles, used for glitches and breaks
  task automatic line(input logic v, input int n);
    rxd = v;
    repeat (n) @(negedge clk_sys);
  endtask
  // idle run on txd, latched at the start edge to judge frame spacing
  always @(negedge clk_sys) hi_cnt <= txd ? hi_cnt + 8'(hi_cnt != 8'hff) : 8'h00;
  // catcher samples mid-bit; returns mid stop so a following start is not missed
  always begin
    @(negedge clk_sys);
    if (txd === 1'b0) begin
      hi_run = hi_cnt;
      w = 9'h000;
      ticks(8);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        ticks(16);
        w[i] = txd;
      end
      ticks(16);
      got = w;
      got_ok = 1'b1;
      @(negedge clk_sys);
      got_ok = 1'b0;
    end
  end
endmodule

// [test/tb.sv]
// self-checking bench for the uart core
`timescale 1ns/1ns
module tb;
  import uart_dbuf_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic sample_tick = 1'b0;
  cfg_s cfg = '0;
  flag_clr_s clr = '0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_ready, txd, rxd, isp_reset, in_stop, got_ok;
  logic isp_seen = 1'b0;
  logic [7:0] rx_data, hi_run;
  logic [8:0] got;
  flags_s flags;
  int failures = 0;
  int checks = 0;
  initial forever #25 clk_sys = ~clk_sys;
  // tick every other cycle, so one bit lasts 32 cycles
  always @(negedge clk_sys) sample_tick <= ~sample_tick;
  always @(posedge clk_sys) if (isp_reset === 1'b1) isp_seen <= 1'b1;
  uart_dbuf_multiproc_break uart_dbuf_multiproc_break_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .sample_tick(sample_tick), .cfg(cfg),
    .clr(clr), .rxd(rxd), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .txd(txd), .rx_data(rx_data), .flags(flags), .isp_reset(isp_reset));
  uart_remote_node uart_remote_node_i (
    .clk_sys(clk_sys), .sample_tick(sample_tick), .nine(cfg.mode[1]), .txd(txd),
    .rxd(rxd), .in_stop(in_stop), .got_ok(got_ok), .got(got), .hi_run(hi_run));
  task automatic chk_word(input logic [8:0] act, input logic [8:0] exp);
    checks++;
    if (act !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic chk_bit(input logic act, input logic exp);
    chk_word({8'h00, act}, {8'h00, exp});
  endtask
  task automatic results();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one buffer write; ninth bit set first and held until the next write
  task automatic put(input logic [8:0] w);
    int n;
    n = 0;
    cfg.tx_ninth_bit = w[8];
    wr_data = w[7:0];
    wr_valid = 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wr_ready !== 1'b1 && n < 2000);
    if (wr_ready !== 1'b1) failures++;
    @(negedge clk_sys);
    wr_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic get(input logic [8:0] exp);
    int n;
    n = 0;
    while (got_ok !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (got_ok !== 1'b1) failures++;
    chk_word(got, exp);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic clear();
    clr = '1;
    @(negedge clk_sys);
    clr = '0;
    @(negedge clk_sys);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    cfg.uart_enable = 1'b1;
    cfg.mode = 2'h2;
    put(9'h1a5);
    get(9'h1a5);
    cfg.tx_double_buffer_enable = 1'b1;
    // first write flags at once; the last one only when selected
    for (int s = 0; s < 2; s++) begin
      cfg.tx_last_irq_select = s[0];
      cfg.tx_irq_position_select = s[0];
      repeat (40) @(negedge clk_sys);
      clear();
      put(9'h03c);
      chk_bit(flags.tx_done_flag, 1'b1);
      clear();
      get(9'h03c);
      repeat (40) @(negedge clk_sys);
      chk_bit(flags.tx_done_flag, s[0]);
    end
    // held buffer: four words fill it, a fifth is refused, then all go back to back
    cfg.uart_enable = 1'b0;
    cfg.tx_last_irq_select = 1'b0;
    for (int i = 0; i < 4; i++) put({i[0], 8'h50 + 8'(i)});
    wr_valid = 1'b1;
    @(posedge clk_sys);
    chk_bit(wr_ready, 1'b0);
    @(negedge clk_sys);
    wr_valid = 1'b0;
    cfg.uart_enable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      get({i[0], 8'h50 + 8'(i)});
      // a ninth bit of one before the stop stretches the idle-looking run by one bit
      if (i > 0) chk_bit(hi_run < (i[0] ? 8'h28 : 8'h48), 1'b1);
    end
    // filter on: data frames dropped, address frames taken while the flag is clear; then filter off takes a data frame
    cfg.mode = 2'h3;
    cfg.multiproc_filter_enable = 1'b1;
    for (int s = 0; s < 2; s++) begin
      cfg.framing_flag_select = s[0];
      clear();
      uart_remote_node_i.send(9'h0a5, 1'b0);
      repeat (20) @(negedge clk_sys);
      chk_bit(flags.rx_done_flag, 1'b0);
      chk_bit(flags.framing_error_flag, !s[0]);
      fork
        uart_remote_node_i.send(9'h15a, 1'b1);
        begin
          @(posedge in_stop);
          repeat (4) @(negedge clk_sys);
          chk_bit(flags.rx_done_flag, !s[0]);
        end
      join
      repeat (20) @(negedge clk_sys);
      chk_word({flags.rx_ninth_bit, rx_data}, 9'h15a);
    end
    uart_remote_node_i.send(9'h177, 1'b1);
    repeat (20) @(negedge clk_sys);
    chk_word({flags.rx_ninth_bit, rx_data}, 9'h15a);
    cfg.multiproc_filter_enable = 1'b0;
    clear();
    uart_remote_node_i.send(9'h0c3, 1'b1);
    repeat (20) @(negedge clk_sys);
    chk_word({flags.rx_done_flag, rx_data}, 9'h1c3);
    // mode 1: eight data bits, the stop bit lands in the ninth-bit flag
    cfg.mode = 2'h1;
    clear();
    uart_remote_node_i.send(9'h03c, 1'b1);
    repeat (20) @(negedge clk_sys);
    chk_word({flags.rx_ninth_bit, rx_data}, 9'h13c);
    chk_bit(flags.framing_error_flag, 1'b0);
    // a short low glitch is not a start bit
    clear();
    uart_remote_node_i.line(1'b0, 8);
    uart_remote_node_i.line(1'b1, 400);
    chk_bit(flags.rx_done_flag | flags.framing_error_flag, 1'b0);
    // ten low bit times are short; eleven set the flag, which then holds
    cfg.break_reset_enable = 1'b1;
    uart_remote_node_i.line(1'b0, 320);
    chk_bit(flags.break_flag, 1'b0);
    uart_remote_node_i.line(1'b0, 40);
    chk_bit(flags.break_flag, 1'b1);
    chk_bit(isp_seen, 1'b1);
    uart_remote_node_i.line(1'b1, 100);
    chk_bit(flags.break_flag, 1'b1);
    clear();
    chk_bit(flags.break_flag, 1'b0);
    results();
  end
  // run needs about 6100 cycles; cut short at 40000
  initial begin
    #2000000;
    failures++;
    results();
  end
endmodule
